// ==== logic/dbt_bank.sv ====
`timescale 1ns/100ps
`include "dbt_cfg.svh"
module dbt_bank (
  input wire logic clk,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [0:`DBT_BANK_WORDS-1];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ==== logic/dbt_cfg.svh ====
`ifndef DBT_CFG_SVH
`define DBT_CFG_SVH
// Notes on behaviour
// - Status bits 31..2 always read zero
// - Bit 1 transfer end, bit 0 ready
// - End flag 1: run program; 0: more
// - Host sets end flag after last session
// - Ready 1: host writes; 0: host has released its bank
// - Device sets ready; host clears after writing
// - Device clears both banks, then sets ready
// - Host waits ready, writes block, clears ready
// - Device flips bank, sets ready, then drains
// - Device clears header after each block
// - Header holds byte size; device moves it rounded up to longwords, at most 255
// - Device moves data as 32-bit longwords
// - Host finishes with single write end=1 ready=0
// - Device runs only on ready 0, end 1
// - Host and device use different banks, except at init when the device clears both
`define DBT_AW 8
`define DBT_BANK_WORDS 256
`define DBT_HDR_ADDR 8'h00
`define DBT_BUF_FIRST 8'h01
`define DBT_BUF_WORDS 9'h0FF
`define DBT_LAST_ADDR 8'hFF
`define DBT_GSR_W 2
`define DBT_GSR_READY 0
`define DBT_GSR_END 1
`define DBT_GSR_RESET 2'h0
`define DBT_GSR_FINISH 32'h0000_0002
`define DBT_GSR_RELEASE 32'h0000_0000
`define DBT_REG_CTRL 2'h0
`define DBT_REG_DATA 2'h1
`define DBT_REG_SIZE 2'h2
`define DBT_CTRL_COMMIT 0
`define DBT_CTRL_FINISH 1
`define DBT_STAT_READY 0
`define DBT_STAT_FILL 1
`define DBT_STAT_DONE 2
`define DBT_STAT_FINPEND 3
`endif

// ==== logic/dbt_device.sv ====
`timescale 1ns/100ps
`include "dbt_cfg.svh"
module dbt_device (
  input wire logic clk,
  input wire logic resetn,
  dbt_if.dev link,
  input wire logic loc_gsr_we,
  input wire logic [31:0] loc_gsr_wdata,
  output logic [31:0] loc_gsr_rdata,
  output logic sd_valid,
  input wire logic sd_ready,
  output logic [15:0] sd_addr,
  output logic [31:0] sd_data,
  output logic bank_select_bit,
  output logic run_program
);
  dbt_pkg::dbt_dev_state_t state;
  dbt_pkg::dbt_dev_state_t next_state;
  logic [`DBT_GSR_W-1:0] gsr;
  logic [`DBT_GSR_W-1:0] next_gsr;
  logic next_bank_select_bit;
  logic [7:0] idx;
  logic [7:0] next_idx;
  logic [8:0] count;
  logic [8:0] next_count;
  logic next_sd_valid;
  logic [15:0] next_sd_addr;
  logic [31:0] next_sd_data;
  logic set_ready;
  logic clear_all;
  logic dev_we;
  logic [7:0] dev_addr;
  logic [31:0] bank_rdata [0:1];
  logic [31:0] dev_rdata;
  logic [32:0] size_round;
  logic [30:0] size_words;

  // Only two flag bits are stored; the rest cannot hold stale data
  assign link.gsr_rdata = {30'h0, gsr};
  assign loc_gsr_rdata = {30'h0, gsr};
  assign run_program = (state == dbt_pkg::DEV_RUN);
  assign dev_rdata = bank_rdata[bank_select_bit];

  // Host sees the bank opposite the select bit, so a flip swaps both
  // sides in the same edge and no access can straddle two banks
  for (genvar g = 0; g < 2; g++) begin : g_bank
    logic host_owns;
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
    assign host_owns = (bank_select_bit != 1'(g));
    always_comb begin
      if (clear_all) begin
        we = 1'b1;
        addr = idx;
        wdata = 32'h0000_0000;
      end else if (host_owns) begin
        we = link.ram_we;
        addr = link.ram_addr;
        wdata = link.ram_wdata;
      end else begin
        we = dev_we;
        addr = dev_addr;
        wdata = 32'h0000_0000;
      end
    end
    dbt_bank u_bank (
      .clk(clk),
      .we(we),
      .addr(addr),
      .wdata(wdata),
      .rdata(bank_rdata[g])
    );
  end

  // Byte size rounds up to whole longwords, capped to the buffer
  always_comb begin
    size_round = {1'b0, dev_rdata} + 33'h0_0000_0003;
    size_words = size_round[32:2];
  end

  // Status register: later writers win, the device set wins last so a
  // clear arriving with the set never loses the ready event
  always_comb begin
    next_gsr = gsr;
    if (loc_gsr_we) begin
      next_gsr = loc_gsr_wdata[`DBT_GSR_W-1:0];
    end
    if (link.gsr_we) begin
      next_gsr = link.gsr_wdata[`DBT_GSR_W-1:0];
    end
    if (set_ready) begin
      next_gsr[`DBT_GSR_READY] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gsr <= `DBT_GSR_RESET;
    end else begin
      gsr <= next_gsr;
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_count = count;
    next_bank_select_bit = bank_select_bit;
    next_sd_valid = sd_valid;
    next_sd_addr = sd_addr;
    next_sd_data = sd_data;
    set_ready = 1'b0;
    clear_all = 1'b0;
    dev_we = 1'b0;
    dev_addr = idx;
    case (state)
      dbt_pkg::DEV_INIT: begin
        clear_all = 1'b1;
        next_idx = idx + 8'h01;
        if (idx == `DBT_LAST_ADDR) begin
          next_state = dbt_pkg::DEV_SET_READY;
        end
      end
      dbt_pkg::DEV_SET_READY: begin
        set_ready = 1'b1;
        next_state = dbt_pkg::DEV_WAIT_HOST;
      end
      dbt_pkg::DEV_WAIT_HOST: begin
        if (!gsr[`DBT_GSR_READY]) begin
          if (gsr[`DBT_GSR_END]) begin
            next_state = dbt_pkg::DEV_RUN;
          end else begin
            next_state = dbt_pkg::DEV_SWAP;
          end
        end
      end
      dbt_pkg::DEV_SWAP: begin
        next_bank_select_bit = ~bank_select_bit;
        next_state = dbt_pkg::DEV_HDR_RD;
      end
      dbt_pkg::DEV_HDR_RD: begin
        set_ready = 1'b1;
        dev_addr = `DBT_HDR_ADDR;
        next_state = dbt_pkg::DEV_HDR_LAT;
      end
      dbt_pkg::DEV_HDR_LAT: begin
        if (size_words > 31'(`DBT_BUF_WORDS)) begin
          next_count = `DBT_BUF_WORDS;
        end else begin
          next_count = size_words[8:0];
        end
        next_idx = `DBT_BUF_FIRST;
        if (size_words == 31'h0000_0000) begin
          next_state = dbt_pkg::DEV_CLR_HDR;
        end else begin
          next_state = dbt_pkg::DEV_RD;
        end
      end
      dbt_pkg::DEV_RD: begin
        dev_addr = idx;
        next_state = dbt_pkg::DEV_LAT;
      end
      dbt_pkg::DEV_LAT: begin
        next_sd_data = dev_rdata;
        next_sd_valid = 1'b1;
        next_state = dbt_pkg::DEV_OUT;
      end
      dbt_pkg::DEV_OUT: begin
        if (sd_ready) begin
          next_sd_valid = 1'b0;
          next_sd_addr = sd_addr + 16'h0001;
          next_idx = idx + 8'h01;
          if ({1'b0, idx} == count) begin
            next_state = dbt_pkg::DEV_CLR_HDR;
          end else begin
            next_state = dbt_pkg::DEV_RD;
          end
        end
      end
      dbt_pkg::DEV_CLR_HDR: begin
        dev_we = 1'b1;
        dev_addr = `DBT_HDR_ADDR;
        next_state = dbt_pkg::DEV_WAIT_HOST;
      end
      dbt_pkg::DEV_RUN: begin
        next_state = dbt_pkg::DEV_RUN;
      end
      default: begin
        next_state = dbt_pkg::DEV_INIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= dbt_pkg::DEV_INIT;
      idx <= 8'h00;
      count <= 9'h000;
      bank_select_bit <= 1'b0;
      sd_valid <= 1'b0;
      sd_addr <= 16'h0000;
      sd_data <= 32'h0000_0000;
    end else begin
      state <= next_state;
      idx <= next_idx;
      count <= next_count;
      bank_select_bit <= next_bank_select_bit;
      sd_valid <= next_sd_valid;
      sd_addr <= next_sd_addr;
      sd_data <= next_sd_data;
    end
  end
endmodule

// ==== logic/dbt_host.sv ====
`timescale 1ns/100ps
`include "dbt_cfg.svh"
module dbt_host (
  input wire logic clk,
  input wire logic resetn,
  dbt_if.host link,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  dbt_pkg::dbt_host_state_t state;
  dbt_pkg::dbt_host_state_t next_state;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic [31:0] size;
  logic [31:0] next_size;
  logic fin_pend;
  logic next_fin_pend;
  logic rd_done;
  logic next_rd_done;
  logic [31:0] next_readdata;
  logic next_ram_we;
  logic [7:0] next_ram_addr;
  logic [31:0] next_ram_wdata;
  logic next_gsr_we;
  logic [31:0] next_gsr_wdata;
  logic wr_ok;
  logic ready_seen;

  assign ready_seen = link.gsr_rdata[`DBT_GSR_READY];

  // Data and commit stall while the shared buffer is not ours
  always_comb begin
    wr_ok = 1'b1;
    if (avs_address == `DBT_REG_DATA) begin
      wr_ok = (state == dbt_pkg::HST_FILL) && (ptr != `DBT_LAST_ADDR);
    end else if (avs_address == `DBT_REG_CTRL && avs_writedata[`DBT_CTRL_COMMIT]) begin
      wr_ok = (state == dbt_pkg::HST_FILL);
    end
    avs_waitrequest = (avs_read && !rd_done) || (avs_write && !wr_ok);
  end

  always_comb begin
    next_state = state;
    next_ptr = ptr;
    next_size = size;
    next_fin_pend = fin_pend;
    next_ram_we = 1'b0;
    next_ram_addr = link.ram_addr;
    next_ram_wdata = link.ram_wdata;
    next_gsr_we = 1'b0;
    next_gsr_wdata = link.gsr_wdata;
    next_readdata = avs_readdata;
    next_rd_done = avs_read && !rd_done;
    if (avs_read && !rd_done) begin
      case (avs_address)
        `DBT_REG_CTRL: next_readdata = {28'h000_0000, fin_pend,
          (state == dbt_pkg::HST_DONE), (state == dbt_pkg::HST_FILL), ready_seen};
        `DBT_REG_SIZE: next_readdata = size;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && wr_ok) begin
      if (avs_address == `DBT_REG_SIZE) begin
        next_size = avs_writedata;
      end
      if (avs_address == `DBT_REG_DATA) begin
        next_ram_we = 1'b1;
        next_ram_addr = ptr;
        next_ram_wdata = avs_writedata;
        next_ptr = ptr + 8'h01;
      end
      if (avs_address == `DBT_REG_CTRL && avs_writedata[`DBT_CTRL_FINISH]) begin
        next_fin_pend = 1'b1;
      end
    end
    case (state)
      dbt_pkg::HST_POLL: begin
        // A release still in flight leaves ready high one more cycle; ignore it
        if (ready_seen && !link.gsr_we) begin
          next_state = fin_pend ? dbt_pkg::HST_FIN : dbt_pkg::HST_FILL;
          next_ptr = `DBT_BUF_FIRST;
        end
      end
      dbt_pkg::HST_FILL: begin
        if (avs_write && avs_address == `DBT_REG_CTRL
            && avs_writedata[`DBT_CTRL_COMMIT]) begin
          next_state = dbt_pkg::HST_HDR;
        end
      end
      dbt_pkg::HST_HDR: begin
        next_ram_we = 1'b1;
        next_ram_addr = `DBT_HDR_ADDR;
        next_ram_wdata = size;
        next_state = dbt_pkg::HST_REL;
      end
      dbt_pkg::HST_REL: begin
        next_gsr_we = 1'b1;
        next_gsr_wdata = `DBT_GSR_RELEASE;
        next_state = dbt_pkg::HST_POLL;
      end
      dbt_pkg::HST_FIN: begin
        next_gsr_we = 1'b1;
        next_gsr_wdata = `DBT_GSR_FINISH;
        next_state = dbt_pkg::HST_DONE;
      end
      dbt_pkg::HST_DONE: begin
        next_state = dbt_pkg::HST_DONE;
      end
      default: begin
        next_state = dbt_pkg::HST_POLL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= dbt_pkg::HST_POLL;
      ptr <= `DBT_BUF_FIRST;
      size <= 32'h0000_0000;
      fin_pend <= 1'b0;
      rd_done <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      link.ram_we <= 1'b0;
      link.ram_addr <= 8'h00;
      link.ram_wdata <= 32'h0000_0000;
      link.gsr_we <= 1'b0;
      link.gsr_wdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      ptr <= next_ptr;
      size <= next_size;
      fin_pend <= next_fin_pend;
      rd_done <= next_rd_done;
      avs_readdata <= next_readdata;
      link.ram_we <= next_ram_we;
      link.ram_addr <= next_ram_addr;
      link.ram_wdata <= next_ram_wdata;
      link.gsr_we <= next_gsr_we;
      link.gsr_wdata <= next_gsr_wdata;
    end
  end
endmodule

// ==== logic/dbt_if.sv ====
`timescale 1ns/100ps
interface dbt_if;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [31:0] ram_wdata;
  logic gsr_we;
  logic [31:0] gsr_wdata;
  logic [31:0] gsr_rdata;
  modport dev (
    input ram_we,
    input ram_addr,
    input ram_wdata,
    input gsr_we,
    input gsr_wdata,
    output gsr_rdata
  );
  modport host (
    output ram_we,
    output ram_addr,
    output ram_wdata,
    output gsr_we,
    output gsr_wdata,
    input gsr_rdata
  );
endinterface

// ==== logic/dbt_pkg.sv ====
package dbt_pkg;
  typedef enum logic [3:0] {
    DEV_INIT = 4'h0,
    DEV_SET_READY = 4'h1,
    DEV_WAIT_HOST = 4'h2,
    DEV_SWAP = 4'h3,
    DEV_HDR_RD = 4'h4,
    DEV_HDR_LAT = 4'h5,
    DEV_RD = 4'h6,
    DEV_LAT = 4'h7,
    DEV_OUT = 4'h8,
    DEV_CLR_HDR = 4'h9,
    DEV_RUN = 4'hA
  } dbt_dev_state_t;
  typedef enum logic [2:0] {
    HST_POLL = 3'h0,
    HST_FILL = 3'h1,
    HST_HDR = 3'h2,
    HST_REL = 3'h3,
    HST_FIN = 3'h4,
    HST_DONE = 3'h5
  } dbt_host_state_t;
endpackage

// ==== verification/dbt_chk.sv ====
`timescale 1ns/100ps
module dbt_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ram_we,
  input wire logic gsr_we,
  input wire logic [31:0] gsr_wdata,
  input wire logic [31:0] gsr_rdata,
  input wire logic sd_valid,
  input wire logic sd_ready,
  input wire logic [31:0] sd_data,
  input wire logic bank_select_bit,
  input wire logic run_program
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  rsvd_zero_a: assert property (gsr_rdata[31:2] == 30'h0)
    else $error("status spare bits not zero");
  swap_ready_a: assert property ($changed(bank_select_bit) |-> ##[1:2] gsr_rdata[0])
    else $error("ready not set after bank flip");
  swap_wait_a: assert property ($changed(bank_select_bit) |-> !$past(gsr_rdata[0]))
    else $error("bank flipped while ready high");
  sd_hold_a: assert property (sd_valid && !sd_ready |=> sd_valid && $stable(sd_data))
    else $error("stream word dropped or changed");
  run_cond_a: assert property ($rose(run_program) |-> gsr_rdata[1:0] == 2'h2)
    else $error("run without end flag and ready low");
  run_keep_a: assert property (run_program |=> run_program)
    else $error("run fell without reset");
  host_fill_a: assert property (ram_we |-> gsr_rdata[0])
    else $error("host wrote buffer while ready low");
  clear_late_a: assert property (gsr_we && gsr_wdata[1:0] == 2'h0 |-> $past(ram_we))
    else $error("ready cleared without a buffer write");
  end_single_a: assert property (gsr_we && gsr_wdata[1] |-> !gsr_wdata[0] && gsr_rdata[0])
    else $error("end flag written wrongly");
endmodule

// ==== verification/dual_bank_transfer_handshake_tb_top.sv ====
`timescale 1ns/100ps
module dual_bank_transfer_handshake_tb_top;
  typedef struct {int bytes; int words;} dbt_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sd_valid;
  logic sd_ready = 1'b0;
  logic [15:0] sd_addr;
  logic [31:0] sd_data;
  logic bank_select_bit;
  logic run_program;
  logic loc_gsr_we = 1'b0;
  logic [31:0] loc_gsr_wdata = 32'h0;
  logic [31:0] loc_gsr_rdata;
  logic [31:0] q;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int nwords = 0;
  int nmoved = 0;
  int nblk = 0;
  logic [31:0] exp_q[$];
  // Sizes not a multiple of four round up to whole longwords
  dbt_row_t rows [5] = '{'{8, 2}, '{5, 2}, '{0, 0}, '{4, 1}, '{13, 4}};
  dbt_if dbt_if_inst ();
  dbt_device dbt_device_inst (.clk(clk), .resetn(resetn), .link(dbt_if_inst.dev),
    .loc_gsr_we(loc_gsr_we), .loc_gsr_wdata(loc_gsr_wdata), .loc_gsr_rdata(loc_gsr_rdata),
    .sd_valid(sd_valid), .sd_ready(sd_ready), .sd_addr(sd_addr), .sd_data(sd_data),
    .bank_select_bit(bank_select_bit), .run_program(run_program));
  dbt_host dbt_host_inst (.clk(clk), .resetn(resetn), .link(dbt_if_inst.host),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dbt_chk dbt_chk_inst (.clk(clk), .resetn(resetn), .ram_we(dbt_if_inst.ram_we),
    .gsr_we(dbt_if_inst.gsr_we), .gsr_wdata(dbt_if_inst.gsr_wdata),
    .gsr_rdata(dbt_if_inst.gsr_rdata), .sd_valid(sd_valid), .sd_ready(sd_ready),
    .sd_data(sd_data), .bank_select_bit(bank_select_bit), .run_program(run_program));
  always #10 clk = ~clk;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Request held until the edge that sees waitrequest low
  task av(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task do_reset(input string nm);
    int n;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("status in reset", 32'h0, dbt_if_inst.gsr_rdata);
    chk("run in reset", 32'h0, {31'h0, run_program});
    @(posedge clk);
    resetn <= 1'b1;
    nwords = 0;
    nmoved = 0;
    nblk = 0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (dbt_if_inst.gsr_rdata[0] !== 1'b1 && n < 400);
    chk("ready delay", 32'd257, 32'(n));
    $display("test %s done", nm);
  endtask
  task send_block(input int bytes, input int words);
    do av(1'b0, 2'h0, 32'h0, q); while (q[1] !== 1'b1);
    chk("bank select", 32'(nblk % 2), {31'h0, bank_select_bit});
    av(1'b1, 2'h2, 32'(bytes), q);
    av(1'b0, 2'h2, 32'h0, q);
    chk("size readback", 32'(bytes), q);
    for (int i = 0; i < words; i++) begin
      exp_q.push_back({16'hC0DE, 16'(nwords)});
      nwords++;
      av(1'b1, 2'h1, exp_q[$], q);
    end
    av(1'b1, 2'h0, 32'h1, q);
    nblk++;
  endtask
  // Stalling pattern keeps the stream waiting on most words
  always @(posedge clk) begin
    cyc++;
    sd_ready <= (cyc % 5) < 2;
    if (resetn && sd_valid === 1'b1 && sd_ready) begin
      if (exp_q.size() == 0) chk("stream extra", 32'h0, 32'h1);
      else chk("stream data", exp_q.pop_front(), sd_data);
      chk("stream addr", 32'(nmoved), {16'h0, sd_addr});
      nmoved++;
    end
    if (cyc > 30000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    do_reset("reset");
    av(1'b1, 2'h3, 32'hFFFFFFFF, q);
    av(1'b0, 2'h3, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    foreach (rows[i]) begin
      send_block(rows[i].bytes, rows[i].words);
      $display("test row %0d done", i);
    end
    send_block(1016, 254);
    av(1'b1, 2'h0, 32'h2, q);
    while (run_program !== 1'b1 || exp_q.size() != 0) @(posedge clk);
    @(negedge clk);
    chk("final status", 32'h2, dbt_if_inst.gsr_rdata);
    chk("local view", 32'h2, loc_gsr_rdata);
    av(1'b0, 2'h0, 32'h0, q);
    chk("host status", 32'hC, q);
    $display("test finish done");
    @(posedge clk);
    loc_gsr_we <= 1'b1;
    loc_gsr_wdata <= 32'hFFFFFFFF;
    @(posedge clk);
    loc_gsr_we <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("local write seen", 32'h3, dbt_if_inst.gsr_rdata);
    $display("test local write done");
    do_reset("mid-run reset");
    final_report();
  end
endmodule
